/* include/svc_pkg.sv */
package svc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_ACCESS   = 8'h04;
	localparam logic [7:0] OFS_CODE_EU  = 8'h08;
	localparam logic [7:0] OFS_CODE_IN  = 8'h0C;
	localparam logic [7:0] OFS_CODE_SV  = 8'h10;
	localparam logic [7:0] OFS_CODE_LB  = 8'h14;
	localparam logic [7:0] OFS_RELAY    = 8'h18;
	localparam logic [7:0] OFS_SPEED    = 8'h1C;
	localparam logic [7:0] OFS_STATUS   = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

	// access code width and reset values (arbitrary defaults)
	localparam int          CODE_W       = 16;
	localparam logic [15:0] RST_CODE_EU  = 16'h0000;
	localparam logic [15:0] RST_CODE_IN  = 16'h0000;
	localparam logic [15:0] RST_CODE_SV  = 16'h0000;
	localparam logic [15:0] RST_CODE_LB  = 16'h0000;

	// speed in percent of the variable band
	localparam logic [6:0] PCT_MIN = 7'h00;
	localparam logic [6:0] PCT_MAX = 7'h64;

	// status field positions
	localparam int ST_MANUAL  = 0;
	localparam int ST_RUNNING = 1;
	localparam int ST_SPEED   = 8;
	localparam int ST_MODE    = 16;

	// event bits of the sticky status
	localparam int EV_SERVICE = 0;
	localparam int EV_DENIED  = 1;
	localparam int EV_REJECT  = 2;
	localparam int EV_W       = 3;

	// operating modes
	typedef enum logic [2:0] {
		MODE_NORMAL  = 3'b000,
		MODE_SERVICE = 3'b001,
		MODE_LAB     = 3'b010,
		MODE_MAKER   = 3'b011,
		MODE_SUPPLY  = 3'b100
	} mode_type;

	// outputs toward the cabinet
	typedef struct packed {
		logic [7:0] relay;
		logic [6:0] speed;
	} drive_type;

endpackage : svc_pkg

/* rtl/service_override.sv */
// Chosen here: the address map and the APB interface to the registers.
module service_override
(
	// clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              SYS_RST,
	// apb slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// normal cabinet control
	input  wire svc_pkg::drive_type NORM_DRIVE,
	// cabinet outputs
	output svc_pkg::drive_type     CAB_DRIVE,
	output svc_pkg::mode_type      MODE_OUT,
	output logic                   IRQ
);
	import svc_pkg::*;

	mode_type              mode_r;      // current operating mode
	logic                  unlock_r;    // service code accepted
	logic                  oem_r;       // lab key presented
	logic [CODE_W-1:0]     code_eu_r;   // end_user_code
	logic [CODE_W-1:0]     code_in_r;   // installer code
	logic [CODE_W-1:0]     code_sv_r;   // service_code
	logic [CODE_W-1:0]     code_lb_r;   // lab_level_code
	logic [7:0]            man_relay_r; // relay_manual_controls
	logic [6:0]            man_speed_r; // manual speed percent
	drive_type             save_r;      // state before service
	logic                  restore_r;   // one cycle of restore
	logic [EV_W-1:0]       ev_stat_r;   // sticky events
	logic [EV_W-1:0]       ev_mask_r;   // event enables
	logic [EV_W-1:0]       ev_set;      // events this cycle
	logic                  acc_go;      // access completes
	logic                  wr_go;       // write completes
	logic                  rd_phase;    // read data capture
	logic                  enter_svc;   // mode goes to service
	logic                  leave_svc;   // mode leaves service
	logic                  mode_wr;     // mode write attempt
	logic                  mode_ok;     // mode write allowed
	logic                  code_wr;     // access code attempt
	logic [31:0]           rd_word;     // read mux
	logic [6:0]            spd_clip;    // clamped setpoint
	mode_type              mode_nxt;    // requested mode

	// ---------------- apb handshake ----------------
	// one wait state so that read data leaves a flip-flop
	assign acc_go   = PSEL && PENABLE && PREADY;
	assign wr_go    = acc_go && PWRITE;
	assign rd_phase = PSEL && PENABLE && !PREADY;

	// ready rises on the second access cycle, then drops
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			PREADY <= 1'b0;
		else
			PREADY <= rd_phase;
	end

	// error on unmapped or misaligned addresses
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			PSLVERR <= 1'b0;
		else if (rd_phase)
			PSLVERR <= (PADDR > OFS_IRQ_MASK) || (PADDR[1:0] != 2'b00);
		else
			PSLVERR <= 1'b0;
	end

	// ---------------- mode selection ----------------
	assign mode_wr  = wr_go && (PADDR == OFS_MODE);
	assign mode_nxt = mode_type'(PWDATA[2:0]);
	// only unlocked, legal codes, lab needs the key
	assign mode_ok  = unlock_r && (PWDATA[2:0] <= 3'h4)
		&& ((mode_nxt != MODE_LAB) || oem_r);
	assign enter_svc = mode_wr && mode_ok && (mode_nxt == MODE_SERVICE)
		&& (mode_r != MODE_SERVICE);
	assign leave_svc = mode_wr && mode_ok && (mode_nxt != MODE_SERVICE)
		&& (mode_r == MODE_SERVICE);

	// mode register
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			mode_r <= MODE_NORMAL;
		else if (mode_wr && mode_ok)
			mode_r <= mode_nxt;
	end

	// ---------------- access codes ----------------
	assign code_wr = wr_go && (PADDR == OFS_ACCESS);

	// a code attempt replaces the previous level
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			unlock_r <= 1'b0;
			oem_r    <= 1'b0;
		end
		else if (code_wr)
		begin
			// lab code also opens the service level
			unlock_r <= (PWDATA[CODE_W-1:0] == code_sv_r) ||
				(PWDATA[CODE_W-1:0] == code_lb_r);
			oem_r    <= (PWDATA[CODE_W-1:0] == code_lb_r);
		end
	end

	// stored codes change only behind the service code
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			code_eu_r <= RST_CODE_EU;
			code_in_r <= RST_CODE_IN;
			code_sv_r <= RST_CODE_SV;
			code_lb_r <= RST_CODE_LB;
		end
		else if (wr_go && unlock_r)
		begin
			if (PADDR == OFS_CODE_EU)
				code_eu_r <= PWDATA[CODE_W-1:0];
			else if (PADDR == OFS_CODE_IN)
				code_in_r <= PWDATA[CODE_W-1:0];
			else if (PADDR == OFS_CODE_SV)
				code_sv_r <= PWDATA[CODE_W-1:0];
			else if (PADDR == OFS_CODE_LB)
				code_lb_r <= PWDATA[CODE_W-1:0];
		end
	end

	// ---------------- manual overrides ----------------
	// setpoints above full band are held at full band
	assign spd_clip = (PWDATA[6:0] > PCT_MAX) ? PCT_MAX : PWDATA[6:0];

	// relay commands; cleared on entry so all start off
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			man_relay_r <= 8'h00;
		else if (enter_svc)
			man_relay_r <= 8'h00;
		else if (wr_go && (PADDR == OFS_RELAY) &&
			(mode_r == MODE_SERVICE))
			man_relay_r <= PWDATA[7:0];
	end

	// speed command; percent of the band, 0 is minimum
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			man_speed_r <= PCT_MIN;
		else if (enter_svc)
			man_speed_r <= PCT_MIN;
		else if (wr_go && (PADDR == OFS_SPEED) &&
			(mode_r == MODE_SERVICE))
			man_speed_r <= spd_clip;
	end

	// snapshot of the normal drive taken at entry
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			save_r <= '0;
		else if (enter_svc)
			save_r <= NORM_DRIVE;
	end

	// restore lasts one cycle, then normal control rules
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			restore_r <= 1'b0;
		else
			restore_r <= leave_svc && (mode_nxt == MODE_NORMAL);
	end

	// ---------------- cabinet outputs ----------------
	// overrides reach the pins only in service mode
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			CAB_DRIVE <= '0;
		else if (enter_svc)
			CAB_DRIVE <= '0;
		else if (mode_r == MODE_SERVICE)
		begin
			CAB_DRIVE.relay <= man_relay_r;
			CAB_DRIVE.speed <= man_speed_r;
		end
		else if (restore_r)
			CAB_DRIVE <= save_r;
		else
			CAB_DRIVE <= NORM_DRIVE;
	end

	// mode shown outside
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			MODE_OUT <= MODE_NORMAL;
		else
			MODE_OUT <= mode_r;
	end

	// ---------------- events ----------------
	assign ev_set[EV_SERVICE] = enter_svc;
	assign ev_set[EV_DENIED]  = code_wr &&
		(PWDATA[CODE_W-1:0] != code_sv_r) &&
		(PWDATA[CODE_W-1:0] != code_lb_r);
	assign ev_set[EV_REJECT]  = mode_wr && !mode_ok;

	// sticky bits; a new event beats a same-cycle clear
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			ev_stat_r <= '0;
		else if (wr_go && (PADDR == OFS_IRQ_STAT))
			ev_stat_r <= (ev_stat_r & ~PWDATA[EV_W-1:0]) | ev_set;
		else
			ev_stat_r <= ev_stat_r | ev_set;
	end

	// mask register
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			ev_mask_r <= '0;
		else if (wr_go && (PADDR == OFS_IRQ_MASK))
			ev_mask_r <= PWDATA[EV_W-1:0];
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			IRQ <= 1'b0;
		else
			IRQ <= |(ev_stat_r & ev_mask_r);
	end

	// ---------------- read path ----------------
	// codes read as zero while locked to keep them hidden
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (PADDR == OFS_MODE)
			rd_word[2:0] = mode_r;
		else if (PADDR == OFS_ACCESS)
			rd_word[1:0] = {oem_r, unlock_r};
		else if (PADDR == OFS_CODE_EU && unlock_r)
			rd_word[CODE_W-1:0] = code_eu_r;
		else if (PADDR == OFS_CODE_IN && unlock_r)
			rd_word[CODE_W-1:0] = code_in_r;
		else if (PADDR == OFS_CODE_SV && unlock_r)
			rd_word[CODE_W-1:0] = code_sv_r;
		else if (PADDR == OFS_CODE_LB && unlock_r)
			rd_word[CODE_W-1:0] = code_lb_r;
		else if (PADDR == OFS_RELAY)
			rd_word[7:0] = man_relay_r;
		else if (PADDR == OFS_SPEED)
			rd_word[6:0] = man_speed_r;
		else if (PADDR == OFS_STATUS)
		begin
			rd_word[ST_MANUAL]  = (MODE_OUT == MODE_SERVICE);
			rd_word[ST_RUNNING] = (CAB_DRIVE.speed != 7'h00);
			rd_word[ST_SPEED +: 7] = CAB_DRIVE.speed;
			rd_word[ST_MODE +: 3]  = MODE_OUT;
		end
		else if (PADDR == OFS_IRQ_STAT)
			rd_word[EV_W-1:0] = ev_stat_r;
		else if (PADDR == OFS_IRQ_MASK)
			rd_word[EV_W-1:0] = ev_mask_r;
	end

	// read data captured in the wait cycle
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			PRDATA <= 32'h0000_0000;
		else if (rd_phase && !PWRITE)
			PRDATA <= rd_word;
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	locked_mode_a: assert property (
		mode_wr && !unlock_r |=> $stable(mode_r))
		else $error("mode changed while locked");
	lab_key_a: assert property (
		mode_r == MODE_LAB && $changed(mode_r) |-> $past(oem_r))
		else $error("lab mode without key");
	entry_off_a: assert property (
		enter_svc |=> CAB_DRIVE == '0 ##1 CAB_DRIVE == '0)
		else $error("outputs not off on service entry");
	relay_ign_a: assert property (
		wr_go && PADDR == OFS_RELAY && mode_r != MODE_SERVICE
		|=> $stable(man_relay_r))
		else $error("relay command taken outside service");
	restore_out_a: assert property (
		leave_svc && mode_nxt == MODE_NORMAL |=> ##1 CAB_DRIVE == save_r)
		else $error("state not restored");
	normal_follow_a: assert property (
		mode_r != MODE_SERVICE && !restore_r && !enter_svc
		|=> CAB_DRIVE == $past(NORM_DRIVE))
		else $error("normal control not followed");
	service_drive_a: assert property (
		mode_r == MODE_SERVICE && !enter_svc |=>
		CAB_DRIVE.relay == $past(man_relay_r))
		else $error("manual relays not applied");
	speed_band_a: assert property (
		man_speed_r <= PCT_MAX)
		else $error("speed above full band");
	alarm_set_a: assert property (
		enter_svc |=> ev_stat_r[EV_SERVICE])
		else $error("service alarm missing");
	code_lock_a: assert property (
		wr_go && !unlock_r |=> $stable(code_sv_r) && $stable(code_eu_r))
		else $error("code changed while locked");

	cov_enter_c: cover property (enter_svc);
	cov_restore_c: cover property (restore_r);
	cov_lab_c: cover property (mode_r == MODE_LAB);
	cov_reject_c: cover property (ev_set[EV_REJECT]);

endmodule : service_override

/* tb/svc_operator.sv */
// front-end operator: apb master issuing parameter accesses
module svc_operator
(
	// clock
	input  wire logic        CLK_SYS,
	// apb master outputs
	output logic             PSEL,
	output logic             PENABLE,
	output logic             PWRITE,
	output logic [7:0]       PADDR,
	output logic [31:0]      PWDATA,
	// apb slave answer
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY,
	input  wire logic        PSLVERR
);
	timeunit 1ns;
	timeprecision 1ns;
	import svc_pkg::*;

	// bus idle from time zero
	initial
	begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
	end

	// one transfer, request held until pready is sampled high
	task automatic xfer
	(
		input  logic        wr,
		input  logic [7:0]  adr,
		input  logic [31:0] wd,
		output logic [31:0] rd,
		output logic        err,
		output int          waits
	);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= adr;
		PWDATA <= wd;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		// no cycle count assumed; the bench watchdog ends a dead wait
		do
		begin
			@(posedge CLK_SYS);
			n++;
		end
		while (PREADY !== 1'b1);
		waits = n;
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// released lines must not keep showing the last value
		PADDR <= ~adr;
		PWDATA <= ~wd;
	endtask : xfer

	// access code goes in before any service function is used
	task automatic unlock(input logic [15:0] code);
		logic [31:0] q;
		logic        e;
		int          h;
		xfer(1'b1, OFS_ACCESS, {16'h0000, code}, q, e, h);
	endtask : unlock
endmodule : svc_operator

/* tb/tb_service_override.sv */
// bench for the service override block
module tb_service_override;
	timeunit 1ns;
	timeprecision 1ns;
	import svc_pkg::*;

	logic        clk_sys;     // 10 mhz system clock
	logic        sys_rst;     // synchronous reset
	logic        psel;        // apb wires
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	drive_type   norm_drive;  // stand-in for normal cabinet control
	drive_type   cab_drive;
	mode_type    mode_out;
	logic        irq;
	int          errors;
	int          samples_checked;
	logic [31:0] q;
	logic        e;
	// speed written and speed expected after the clamp
	localparam logic [6:0] SPD_W [4] = '{7'h32, 7'h78, 7'h64, 7'h00};
	localparam logic [6:0] SPD_X [4] = '{7'h32, 7'h64, 7'h64, 7'h00};

	service_override u_dut
	(
		.CLK_SYS   (clk_sys),
		.SYS_RST   (sys_rst),
		.PSEL      (psel),
		.PENABLE   (penable),
		.PWRITE    (pwrite),
		.PADDR     (paddr),
		.PWDATA    (pwdata),
		.PRDATA    (prdata),
		.PREADY    (pready),
		.PSLVERR   (pslverr),
		.NORM_DRIVE(norm_drive),
		.CAB_DRIVE (cab_drive),
		.MODE_OUT  (mode_out),
		.IRQ       (irq)
	);

	svc_operator u_op
	(
		.CLK_SYS(clk_sys),
		.PSEL   (psel),
		.PENABLE(penable),
		.PWRITE (pwrite),
		.PADDR  (paddr),
		.PWDATA (pwdata),
		.PRDATA (prdata),
		.PREADY (pready),
		.PSLVERR(pslverr)
	);

	// clock generator
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// verdict, single exit of the run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// compare and report
	task automatic chk(input string nm, input logic [31:0] x, logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// bus access; the slave answers after exactly one wait state
	task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
		int h;
		u_op.xfer(w, a, d, q, e, h);
		chk("wait states", 32'h2, h);
	endtask : bus

	task automatic wr(input logic [7:0] a, logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input string nm, logic [7:0] a, logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(nm, x, q);
	endtask : rd

	// wait n edges, then look after the updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic cab(input string nm, logic [14:0] x);
		chk(nm, {17'h0, x}, {17'h0, cab_drive});
	endtask : cab

	// expected status word
	function automatic logic [31:0] st(logic [2:0] m, logic [6:0] s, logic mn);
		return {13'h0, m, 1'b0, s, 6'h0, s != 7'h00, mn};
	endfunction : st

	// hang guard, well beyond the length of the sequence
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		errors = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		norm_drive = {8'hA5, 7'h30};
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd("mode", OFS_MODE, 32'h0);
		rd("mask", OFS_IRQ_MASK, 32'h0);
		rd("access", OFS_ACCESS, 32'h0);
		bus(1'b0, 8'h2C, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		wr(OFS_MODE, 32'h1);
		rd("mode lock", OFS_MODE, 32'h0);
		rd("ev lock", OFS_IRQ_STAT, 32'h4);
		wr(OFS_RELAY, 32'hFF);
		settle(2);
		cab("relay normal", {8'hA5, 7'h30});
		wr(OFS_CODE_SV, 32'hAB);
		wr(OFS_ACCESS, 32'h1234);
		rd("ev denied", OFS_IRQ_STAT, 32'h6);
		u_op.unlock(16'h0000);
		bus(1'b0, OFS_ACCESS, 32'h0);
		chk("unlocked", 32'h1, q & 32'h1);
		rd("code kept", OFS_CODE_SV, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_CODE_EU + 8'(4 * i), 32'h1001 + i);
			rd("code", OFS_CODE_EU + 8'(4 * i), 32'h1001 + i);
		end
		wr(OFS_ACCESS, 32'h5555);
		rd("code locked", OFS_CODE_EU, 32'h0);
		u_op.unlock(16'h1003);
		rd("sv unlock", OFS_ACCESS, 32'h1);
		wr(OFS_IRQ_STAT, 32'h7);
		wr(OFS_MODE, 32'h2);
		wr(OFS_MODE, 32'h5);
		rd("mode rej", OFS_MODE, 32'h0);
		rd("ev rej", OFS_IRQ_STAT, 32'h4);
		wr(OFS_IRQ_STAT, 32'h7);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_MODE, 32'h1);
		settle(2);
		cab("entry", 15'h0000);
		chk("irq", 32'h1, {31'h0, irq});
		rd("ev svc", OFS_IRQ_STAT, 32'h1);
		rd("st entry", OFS_STATUS, st(3'h1, 7'h00, 1'b1));
		wr(OFS_IRQ_STAT, 32'h1);
		settle(2);
		chk("irq clr", 32'h0, {31'h0, irq});
		@(posedge clk_sys);
		norm_drive <= {8'h0F, 7'h11};
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_RELAY, 32'h01 << i);
			settle(2);
			cab("relay", {8'h01 << i, 7'h00});
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_SPEED, {25'h0, SPD_W[i]});
			rd("speed", OFS_STATUS, st(3'h1, SPD_X[i], 1'b1));
		end
		wr(OFS_RELAY, 32'h3C);
		wr(OFS_SPEED, 32'h32);
		settle(2);
		cab("manual", {8'h3C, 7'h32});
		wr(OFS_MODE, 32'h0);
		// saved state stands for one cycle only, then normal control
		settle(1);
		cab("restore", {8'hA5, 7'h30});
		settle(1);
		cab("resume", {8'h0F, 7'h11});
		rd("st normal", OFS_STATUS, st(3'h0, 7'h11, 1'b0));
		wr(OFS_RELAY, 32'hFF);
		settle(2);
		cab("ignored", {8'h0F, 7'h11});
		for (int m = 3; m < 5; m++)
		begin
			wr(OFS_MODE, m);
			settle(2);
			chk("mode_out", m, {29'h0, mode_out});
			cab("other", {8'h0F, 7'h11});
		end
		u_op.unlock(16'h1004);
		rd("lab key", OFS_ACCESS, 32'h3);
		wr(OFS_MODE, 32'h2);
		rd("lab mode", OFS_MODE, 32'h2);
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_MODE, 32'h1);
		settle(2);
		cab("re-entry", 15'h0000);
		chk("irq mask", 32'h0, {31'h0, irq});
		rd("ev masked", OFS_IRQ_STAT, 32'h1);
		tally_and_finish();
	end
endmodule : tb_service_override
